// >>> logic/php_consts.svh
// Purpose: constants of the parallel host command port
// Assumes: included by its bare name
// Notes:   codes, status bit positions, reset values
// What this block does
// - sixteen bit status word readable by host
// - status read: select high, read high
// - bit 15 shows instruction in progress
// - bit 14 shows word ready to fetch
// - bit 13 shows word wanted from host
// - bit 12 flags wrong identity in setup
// - bit 11 flags corrupt setup data
// - bit 10 flags arithmetic overflow
// - bits 9..1 echo nine instruction bits
// - bit 0 shows setup done, ready
// - decode identity read and results read
// - setup write requests each word after the first by interrupt
// - data write chip select fall clears request
// - extra interrupt after last setup word
// - unmasked setup interrupts on load error
// - corrupt setup never committed
// - masked setup raises no error interrupts
// - masked setup takes all 504 words
// - zero instruction aborts, stays configured
// - rom boot loads default filter
// - results read: interrupt until word read
// - select pins choose four cycle kinds
// - instruction write clears interrupt; status read clears it unless results wait or, in idle, an identity word waits
// - interrupt raised after power-on reset
`ifndef PHP_CONSTS_SVH
`define PHP_CONSTS_SVH
// ----------------------------------------
// instruction codes
// ----------------------------------------
`define PHP_READ_IDENTITY_CMD      16'h8802
`define PHP_READ_RESULTS_CMD       16'h8d21
`define PHP_WRITE_SETUP_CMD        16'h1800
`define PHP_WRITE_SETUP_MASKED_CMD 16'h1a00
`define PHP_ABORT_CMD              16'h0000
`define PHP_ROM_BOOT_CMD           16'h2000
// ----------------------------------------
// status bit positions
// ----------------------------------------
`define PHP_ST_BUSY   15
`define PHP_ST_RDY    14
`define PHP_ST_REQ    13
`define PHP_ST_IDERR  12
`define PHP_ST_CRCERR 11
`define PHP_ST_OVF    10
`define PHP_ST_DONE   0
// ----------------------------------------
// setup length and reset values
// ----------------------------------------
`define PHP_SETUP_BLOCKS 12
`define PHP_WORDS_PER_BLOCK 42
`define PHP_DATA_RST 16'h0000
`endif

// >>> logic/php_pkg.sv
// Purpose: types of the parallel host command port
// Assumes: nothing
// Notes:   gray coded main states
package php_pkg;
   typedef enum logic [1:0] {
      PHP_IDLE = 2'b00,
      PHP_CFG  = 2'b01,
      PHP_CONV = 2'b11,
      PHP_BOOT = 2'b10
   } php_state_e;
endpackage : php_pkg

// >>> logic/php_port.sv
// Purpose: parallel host port with instruction decode and status
// Assumes: host holds pins steady while chip select is low
// Notes:   pins pass two flops; cycle acts on chip select edges
`timescale 1ns/1ps
`include "php_consts.svh"
module php_port
   import php_pkg::*;
#(
   parameter int          CFG_WORDS = `PHP_SETUP_BLOCKS * `PHP_WORDS_PER_BLOCK,
   parameter int          DEPTH     = 2,
   parameter logic [15:0] ID_WORD   = 16'h5a01  // arbitrary value
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // host pins
   input  wire logic        cs_n,
   input  wire logic        register_select,
   input  wire logic        rd_wr,
   input  wire logic [15:0] data_in,
   output logic      [15:0] data_out,
   output logic             data_oe,
   output logic             irq,
   // result stream from the filter
   input  wire logic        res_valid,
   input  wire logic [15:0] res_data,
   output logic             res_ready,
   input  wire logic        res_overflow,
   // setup path to the filter processor
   output logic      [15:0] cfg_data,
   output logic             cfg_wr,
   output logic             cfg_commit,
   output logic             cfg_discard,
   input  wire logic        chk_crc_bad,
   input  wire logic        chk_id_bad,
   output logic             rom_boot,
   input  wire logic        rom_done
);
   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   if (CFG_WORDS < 1 || CFG_WORDS > 1023) begin : g_bad_words
      $error("CFG_WORDS out of range");
   end
   if (DEPTH != 2) begin : g_bad_depth
      $error("DEPTH must be 2");
   end
   localparam int AW = $clog2(DEPTH);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [18:0] pin_s1_ff;  // first stage, read by second only
   logic [18:0] pin_s2_ff;  // settled pins
   logic        cs_old_ff;  // chip select one cycle back
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pin_s1_ff <= 19'h40000;
         pin_s2_ff <= 19'h40000;
         cs_old_ff <= 1'b1;
      end else begin
         pin_s1_ff <= {cs_n, register_select, rd_wr, data_in};
         pin_s2_ff <= pin_s1_ff;
         cs_old_ff <= pin_s2_ff[18];
      end
   end
   logic        cs_s, rs_s, rw_s;
   logic [15:0] word_s;
   logic        cs_fall, cs_rise;
   assign cs_s   = pin_s2_ff[18];
   assign rs_s   = pin_s2_ff[17];
   assign rw_s   = pin_s2_ff[16];
   assign word_s = pin_s2_ff[15:0];
   assign cs_fall = cs_old_ff & ~cs_s;
   assign cs_rise = ~cs_old_ff & cs_s;
   // cycle kinds; writes take the word at the end of the cycle
   logic wr_instr, wr_data, rd_stat, rd_data, wr_start;
   assign wr_instr = cs_rise & ~rw_s & rs_s;
   assign wr_data  = cs_rise & ~rw_s & ~rs_s;
   assign wr_start = cs_fall & ~rw_s & ~rs_s;
   assign rd_stat  = cs_fall & rw_s & rs_s;
   assign rd_data  = cs_fall & rw_s & ~rs_s;
   // ----------------------------------------
   // state
   // ----------------------------------------
   php_state_e  st_ff, nxt_st;
   logic [9:0]  wcnt_ff, nxt_wcnt;      // setup words taken
   logic        masked_ff, nxt_masked;  // errors kept off the line
   logic        id_pend_ff, nxt_id_pend;
   logic        req_ff, nxt_req;
   logic        iderr_ff, nxt_iderr;
   logic        crcerr_ff, nxt_crcerr;
   logic        ovf_ff, nxt_ovf;
   logic        done_ff, nxt_done;
   logic        por_ff, nxt_por;        // power-on request pending
   logic [8:0]  echo_ff, nxt_echo;      // mirrored instruction bits
   logic [15:0] dout_ff, nxt_dout;
   logic        oe_ff, nxt_oe;
   logic        irq_ff, nxt_irq;
   logic [15:0] cdat_ff, nxt_cdat;
   logic        cwr_ff, nxt_cwr;
   logic        cmt_ff, nxt_cmt;
   logic        dsc_ff, nxt_dsc;
   logic        boot_ff, nxt_boot;
   // result buffer
   logic [15:0] buf_mem [DEPTH];
   logic [AW:0] cnt_ff, nxt_cnt;
   logic [AW-1:0] wp_ff, rp_ff;
   logic        rdy_ff, nxt_rdy;
   logic        push, pop;
   // ----------------------------------------
   // status word
   // ----------------------------------------
   function automatic logic [8:0] php_echo(input logic [15:0] c);
      php_echo = {c[15], c[13], c[12], c[11], c[6], c[5], c[4], c[1], c[0]};
   endfunction : php_echo
   logic [15:0] status;
   logic        data_rdy;
   assign data_rdy = id_pend_ff | (st_ff == PHP_CONV && cnt_ff != '0);
   always_comb begin
      status = 16'h0000;
      status[`PHP_ST_BUSY]   = (st_ff != PHP_IDLE) | id_pend_ff;
      status[`PHP_ST_RDY]    = data_rdy;
      status[`PHP_ST_REQ]    = req_ff;
      status[`PHP_ST_IDERR]  = iderr_ff;
      status[`PHP_ST_CRCERR] = crcerr_ff;
      status[`PHP_ST_OVF]    = ovf_ff;
      status[9:1]            = echo_ff;
      status[`PHP_ST_DONE]   = done_ff;
   end
   // ----------------------------------------
   // buffer moves
   // ----------------------------------------
   assign push = res_valid & rdy_ff;
   assign pop  = rd_data & ~id_pend_ff & (st_ff == PHP_CONV) & (cnt_ff != '0);
   always_comb begin
      nxt_cnt = cnt_ff;
      if (st_ff != PHP_CONV) begin
         nxt_cnt = '0;  // abort flushes stale results
      end else if (push & ~pop) begin
         nxt_cnt = cnt_ff + 1'b1;
      end else if (pop & ~push) begin
         nxt_cnt = cnt_ff - 1'b1;
      end
      // registered ready: only in conversion, so no result is swallowed while idle
      nxt_rdy = (nxt_st == PHP_CONV) & ((nxt_cnt < (AW+1)'(DEPTH - 1)) | ((nxt_cnt == (AW+1)'(DEPTH - 1)) & ~push));
   end
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= '0;
         wp_ff  <= '0;
         rp_ff  <= '0;
         rdy_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         rdy_ff <= nxt_rdy;
         wp_ff  <= (st_ff != PHP_CONV) ? '0 : wp_ff + AW'(push);
         rp_ff  <= (st_ff != PHP_CONV) ? '0 : rp_ff + AW'(pop);
      end
   end
   always_ff @(posedge clk_sys) begin
      if (push) begin
         buf_mem[wp_ff] <= res_data;
      end
   end
   // ----------------------------------------
   // decode, sequencing and interrupt
   // ----------------------------------------
   logic last_word, load_err, irq_set, irq_clr;
   assign last_word = wcnt_ff == 10'(CFG_WORDS - 1);
   assign load_err  = chk_crc_bad | chk_id_bad;
   always_comb begin
      nxt_st = st_ff;
      nxt_wcnt = wcnt_ff;
      nxt_masked = masked_ff;
      nxt_id_pend = id_pend_ff;
      nxt_req = req_ff;
      nxt_iderr = iderr_ff | (st_ff == PHP_CFG & chk_id_bad);
      nxt_crcerr = crcerr_ff | (st_ff == PHP_CFG & chk_crc_bad);
      nxt_ovf = ovf_ff | (st_ff == PHP_CONV & res_overflow);
      nxt_done = done_ff;
      nxt_por = 1'b0;
      nxt_echo = echo_ff;
      nxt_cwr = 1'b0;
      nxt_cmt = 1'b0;
      nxt_dsc = 1'b0;
      nxt_boot = 1'b0;
      nxt_cdat = cdat_ff;
      irq_set = por_ff;
      irq_clr = wr_instr | rd_stat | wr_start;
      // host read: drive chosen word until the cycle ends
      nxt_oe = oe_ff;
      nxt_dout = dout_ff;
      if (rd_stat) begin
         nxt_dout = status;
         nxt_oe = 1'b1;
      end else if (rd_data) begin
         nxt_dout = id_pend_ff ? ID_WORD : (pop ? buf_mem[rp_ff] : `PHP_DATA_RST);
         nxt_oe = 1'b1;
         nxt_id_pend = 1'b0;
      end else if (cs_rise) begin
         nxt_oe = 1'b0;
      end
      case (st_ff)
         PHP_CFG: begin
            if (load_err & ~masked_ff) begin
               nxt_st = PHP_IDLE;
               nxt_req = 1'b0;
               nxt_dsc = 1'b1;
               irq_set = 1'b1;
            end else if (wr_data & req_ff) begin
               nxt_cdat = word_s;
               nxt_cwr = 1'b1;
               nxt_wcnt = wcnt_ff + 10'h001;
               irq_set = 1'b1;
               if (last_word) begin
                  nxt_st = PHP_IDLE;
                  nxt_req = 1'b0;
                  if (crcerr_ff | iderr_ff | load_err) begin
                     nxt_dsc = 1'b1;
                  end else begin
                     nxt_cmt = 1'b1;
                     nxt_done = 1'b1;
                  end
               end
            end
         end
         PHP_BOOT: begin
            if (rom_done) begin
               nxt_st = PHP_IDLE;
               nxt_done = 1'b1;
               irq_set = 1'b1;
            end
         end
         PHP_CONV: begin
            irq_clr = irq_clr | rd_data;  // a data read drops the line
            irq_set = (cnt_ff != '0) & ~pop;
         end
         PHP_IDLE: begin
            irq_set = irq_set | (id_pend_ff & ~rd_data);
         end
         default: begin
            nxt_st = PHP_IDLE;
         end
      endcase
      if (wr_instr) begin
         nxt_echo = php_echo(word_s);
         nxt_id_pend = 1'b0;
         case (word_s)
            `PHP_READ_IDENTITY_CMD: begin
               nxt_id_pend = 1'b1;
            end
            `PHP_READ_RESULTS_CMD: begin
               nxt_st = PHP_CONV;
               nxt_ovf = 1'b0;
            end
            `PHP_WRITE_SETUP_CMD, `PHP_WRITE_SETUP_MASKED_CMD: begin
               nxt_st = PHP_CFG;
               nxt_masked = word_s == `PHP_WRITE_SETUP_MASKED_CMD;
               nxt_wcnt = 10'h000;
               nxt_req = 1'b1;
               nxt_iderr = 1'b0;
               nxt_crcerr = 1'b0;
               nxt_done = 1'b0;
            end
            `PHP_ROM_BOOT_CMD: begin
               nxt_st = PHP_BOOT;
               nxt_boot = 1'b1;
               nxt_iderr = 1'b0;
               nxt_crcerr = 1'b0;
               nxt_done = 1'b0;
            end
            `PHP_ABORT_CMD: begin
               nxt_st = PHP_IDLE;
               nxt_req = 1'b0;
            end
            default: begin
               nxt_st = st_ff;
            end
         endcase
         irq_set = 1'b0;
      end
      // a set in the same cycle as a clear wins
      nxt_irq = irq_set | (irq_ff & ~irq_clr);
   end
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff <= PHP_IDLE;
         wcnt_ff <= 10'h000;
         masked_ff <= 1'b0;
         id_pend_ff <= 1'b0;
         req_ff <= 1'b0;
         iderr_ff <= 1'b0;
         crcerr_ff <= 1'b0;
         ovf_ff <= 1'b0;
         done_ff <= 1'b0;
         por_ff <= 1'b1;
         echo_ff <= 9'h000;
         dout_ff <= `PHP_DATA_RST;
         oe_ff <= 1'b0;
         irq_ff <= 1'b0;
         cdat_ff <= `PHP_DATA_RST;
         cwr_ff <= 1'b0;
         cmt_ff <= 1'b0;
         dsc_ff <= 1'b0;
         boot_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         wcnt_ff <= nxt_wcnt;
         masked_ff <= nxt_masked;
         id_pend_ff <= nxt_id_pend;
         req_ff <= nxt_req;
         iderr_ff <= nxt_iderr;
         crcerr_ff <= nxt_crcerr;
         ovf_ff <= nxt_ovf;
         done_ff <= nxt_done;
         por_ff <= nxt_por;
         echo_ff <= nxt_echo;
         dout_ff <= nxt_dout;
         oe_ff <= nxt_oe;
         irq_ff <= nxt_irq;
         cdat_ff <= nxt_cdat;
         cwr_ff <= nxt_cwr;
         cmt_ff <= nxt_cmt;
         dsc_ff <= nxt_dsc;
         boot_ff <= nxt_boot;
      end
   end
   assign data_out = dout_ff;
   assign data_oe = oe_ff;
   assign irq = irq_ff;
   assign res_ready = rdy_ff;
   assign cfg_data = cdat_ff;
   assign cfg_wr = cwr_ff;
   assign cfg_commit = cmt_ff;
   assign cfg_discard = dsc_ff;
   assign rom_boot = boot_ff;
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   sequence s_setup_cmd;
      wr_instr && (word_s == `PHP_WRITE_SETUP_CMD || word_s == `PHP_WRITE_SETUP_MASKED_CMD);
   endsequence
   sequence s_last_ok;
      st_ff == PHP_CFG && wr_data && req_ff && last_word && !load_err && !wr_instr;
   endsequence
   busy_after_setup_a: assert property (s_setup_cmd |=> status[15] && status[13] && !status[0])
      else $error("setup not busy");
   status_echo_a: assert property (wr_instr |=> echo_ff == php_echo($past(word_s)))
      else $error("echo wrong");
   err_clear_a: assert property (s_setup_cmd |=> !status[12] && !status[11])
      else $error("errors kept");
   req_clear_a: assert property (wr_start && !irq_set |=> !irq_ff)
      else $error("request not cleared");
   last_done_a: assert property (s_last_ok ##0 (!crcerr_ff && !iderr_ff) |=> irq_ff && cfg_commit && st_ff == PHP_IDLE)
      else $error("no done interrupt");
   no_bad_commit_a: assert property (cfg_commit |-> !crcerr_ff && !iderr_ff)
      else $error("corrupt committed");
   masked_quiet_a: assert property ($rose(irq_ff) && $past(st_ff) == PHP_CFG && masked_ff |-> $past(wr_data))
      else $error("masked error interrupt");
   abort_idle_a: assert property (wr_instr && word_s == `PHP_ABORT_CMD |=> st_ff == PHP_IDLE && $stable(done_ff))
      else $error("abort failed");
   conv_irq_a: assert property (st_ff == PHP_CONV && cnt_ff != '0 && !pop && !wr_instr |=> irq_ff && status[14])
      else $error("ready not flagged");
endmodule : php_port

// >>> test/php_filter_model.sv
// Purpose: filter side stand-in: result source, setup sink, checker, rom
// Assumes: bench steers crc_mode, id_mode and send_n by hierarchy
// Notes:   results hold until taken, so a slow host never loses one
`timescale 1ns/1ps
module php_filter_model (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // result stream
   output logic             res_valid,
   output logic      [15:0] res_data,
   input  wire logic        res_ready,
   output logic             res_overflow,
   // setup path
   input  wire logic [15:0] cfg_data,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_commit,
   input  wire logic        cfg_discard,
   output logic             chk_crc_bad,
   output logic             chk_id_bad,
   input  wire logic        rom_boot,
   output logic             rom_done
);
   logic        crc_mode   = 1'b0;  // checker reports corrupt data
   logic        id_mode    = 1'b0;  // checker reports wrong identity
   logic [15:0] send_n     = 16'h0000; // results to offer
   logic [15:0] idx;                // results already taken
   logic [15:0] last_cfg;           // last setup word seen
   int          wr_cnt, commit_cnt, discard_cnt, boot_cnt;
   logic [4:0]  boot_tmr;           // rom load takes a while, not instant
   assign chk_crc_bad = crc_mode;
   assign chk_id_bad  = id_mode;
   // ------------------------------------------------
   // stream, setup sink and rom timer
   // ------------------------------------------------
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         res_valid <= 1'b0;
         res_data <= 16'h0000;
         res_overflow <= 1'b0;
         idx <= 16'h0000;
         boot_tmr <= 5'h00;
         rom_done <= 1'b0;
         last_cfg <= 16'h0000;
         wr_cnt <= 0;
         commit_cnt <= 0;
         discard_cnt <= 0;
         boot_cnt <= 0;
      end else begin
         res_overflow <= 1'b0;
         if (res_valid && res_ready) begin
            idx <= idx + 16'h0001;
            res_valid <= 1'b0;
            res_data <= ~res_data;                // released line keeps no value
            res_overflow <= (idx == 16'h0002);
         end else if (!res_valid && idx < send_n) begin
            res_valid <= 1'b1;
            res_data <= 16'hc000 + idx;
         end else if (!res_valid) begin
            res_data <= ~res_data;
         end
         if (rom_boot) boot_tmr <= 5'h14;
         else if (boot_tmr != 5'h00) boot_tmr <= boot_tmr - 5'h01;
         rom_done <= (boot_tmr == 5'h01);
         if (cfg_wr) begin
            wr_cnt <= wr_cnt + 1;
            last_cfg <= cfg_data;
         end
         if (cfg_commit) commit_cnt <= commit_cnt + 1;
         if (cfg_discard) discard_cnt <= discard_cnt + 1;
         if (rom_boot) boot_cnt <= boot_cnt + 1;
      end
   end
endmodule : php_filter_model

// >>> test/php_port_tb_top.sv
// Purpose: host side bench of the parallel host command port
// Assumes: short setup file of four words
// Notes:   each host cycle keeps pins steady well past chip select rise
`timescale 1ns/1ps
module php_port_tb_top;
   import php_pkg::*;
   localparam logic [15:0] ID_VAL = 16'h3c7e;  // arbitrary value
   logic clk_sys, sys_rst, cs_n, register_select, rd_wr;
   logic [15:0] data_in, data_out, res_data, cfg_data;
   logic data_oe, irq, res_valid, res_ready, res_overflow, cfg_wr, cfg_commit;
   logic cfg_discard, chk_crc_bad, chk_id_bad, rom_boot, rom_done;
   int   err_total, check_count;
   php_port #(.CFG_WORDS(4), .DEPTH(2), .ID_WORD(ID_VAL)) u_dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(cs_n), .register_select(register_select),
      .rd_wr(rd_wr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .irq(irq),
      .res_valid(res_valid), .res_data(res_data), .res_ready(res_ready), .res_overflow(res_overflow),
      .cfg_data(cfg_data), .cfg_wr(cfg_wr), .cfg_commit(cfg_commit), .cfg_discard(cfg_discard),
      .chk_crc_bad(chk_crc_bad), .chk_id_bad(chk_id_bad), .rom_boot(rom_boot), .rom_done(rom_done));
   php_filter_model u_flt (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .res_valid(res_valid), .res_data(res_data),
      .res_ready(res_ready), .res_overflow(res_overflow), .cfg_data(cfg_data), .cfg_wr(cfg_wr),
      .cfg_commit(cfg_commit), .cfg_discard(cfg_discard), .chk_crc_bad(chk_crc_bad),
      .chk_id_bad(chk_id_bad), .rom_boot(rom_boot), .rom_done(rom_done));
   // ------------------------------------------------
   // compare and report
   // ------------------------------------------------
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] msk);
      check_count++;
      if ((got & msk) !== (exp & msk)) begin
         err_total++;
         $display("[ERR] %0t word %h want %h mask %h", $time, got, exp, msk);
      end
   endtask : cmp
   task automatic cmp1(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t flag %b want %b", $time, got, exp);
      end
   endtask : cmp1
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict
   // ------------------------------------------------
   // host cycles
   // ------------------------------------------------
   task automatic bus(input logic rs, input logic rw, input logic [15:0] wd, output logic [15:0] q);
      int n;
      q = 16'h0000;
      n = 0;
      @(posedge clk_sys);
      cs_n <= 1'b0;
      register_select <= rs;
      rd_wr <= rw;
      data_in <= wd;
      repeat (4) @(posedge clk_sys);
      #1;
      if (!rw && !rs) cmp1(irq, 1'b0);
      while (rw && data_oe !== 1'b1 && n < 12) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (rw) cmp1(data_oe, 1'b1);
      q = data_out;
      @(posedge clk_sys);
      cs_n <= 1'b1;
      repeat (8) @(posedge clk_sys);              // pins stay put while sync catches up
   endtask : bus
   task automatic ins(input logic [15:0] c);
      logic [15:0] d;
      bus(1'b1, 1'b0, c, d);
   endtask : ins
   task automatic wdat(input logic [15:0] w);
      logic [15:0] d;
      bus(1'b0, 1'b0, w, d);
   endtask : wdat
   task automatic st(input logic [15:0] exp, input logic [15:0] msk);
      logic [15:0] d;
      bus(1'b1, 1'b1, 16'h0000, d);
      cmp(d, exp, msk);
   endtask : st
   task automatic rdat(input logic [15:0] exp);
      logic [15:0] d;
      bus(1'b0, 1'b1, 16'h0000, d);
      cmp(d, exp, 16'hffff);
   endtask : rdat
   task automatic flag(input logic e);
      @(posedge clk_sys);
      #1;
      cmp1(irq, e);
   endtask : flag
   function automatic logic [15:0] echo(input logic [15:0] i);
      return {6'h00, i[15], i[13], i[12], i[11], i[6], i[5], i[4], i[1], i[0], 1'b0};
   endfunction : echo
   // ------------------------------------------------
   // clock, watchdog, tests
   // ------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      #160000;                                    // tests need about 550 cycles
      err_total++;
      give_verdict();
   end
   initial begin
      err_total = 0;
      check_count = 0;
      sys_rst = 1'b1;
      cs_n = 1'b1;
      register_select = 1'b0;
      rd_wr = 1'b1;
      data_in = 16'h0000;
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (2) flag(1'b1);
      st(16'h0000, 16'hffff);
      flag(1'b0);
      $display("test reset done");
      ins(16'h8802);
      flag(1'b1);
      st(16'hc000 | echo(16'h8802), 16'hffff);
      rdat(ID_VAL);
      st(echo(16'h8802), 16'hffff);
      $display("test identity done");
      ins(16'h1800);
      st(16'ha000 | echo(16'h1800), 16'hffff);
      for (int i = 0; i < 4; i++) begin
         wdat(16'h1100 + i[15:0]);
         flag(1'b1);
      end
      cmp(u_flt.last_cfg, 16'h1103, 16'hffff);
      cmp(u_flt.commit_cnt[15:0], 16'h0001, 16'hffff);
      st(16'h0001 | echo(16'h1800), 16'hffff);
      $display("test setup done");
      ins(16'h1a00);
      u_flt.crc_mode <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         wdat(16'h2200 + i[15:0]);
         if (i == 1) st(16'h2000, 16'h2000);
      end
      u_flt.crc_mode <= 1'b0;
      flag(1'b1);
      cmp(u_flt.wr_cnt[15:0], 16'h0008, 16'hffff);
      cmp(u_flt.commit_cnt[15:0], 16'h0001, 16'hffff);
      st(16'h0800, 16'hb800);
      $display("test masked setup done");
      ins(16'h1800);
      u_flt.id_mode <= 1'b1;
      flag(1'b1);
      u_flt.id_mode <= 1'b0;
      wdat(16'h3300);
      cmp(u_flt.wr_cnt[15:0], 16'h0008, 16'hffff);
      st(16'h1000, 16'hb800);
      cmp(u_flt.discard_cnt[15:0], 16'h0002, 16'hffff);
      $display("test setup error done");
      ins(16'h2000);
      repeat (40) @(posedge clk_sys);             // model takes 20 cycles to load
      cmp(u_flt.boot_cnt[15:0], 16'h0001, 16'hffff);
      st(16'h0001, 16'h9801);
      $display("test rom boot done");
      u_flt.send_n <= 16'h0003;
      ins(16'h8d21);
      repeat (30) @(posedge clk_sys);             // buffer fills, third word stalls
      flag(1'b1);
      st(16'hc000, 16'hc000);
      for (int i = 0; i < 3; i++) begin
         rdat(16'hc000 + i[15:0]);
         flag(1'(i < 2));
      end
      st(16'h0400, 16'h4400);
      ins(16'h0000);
      st(16'h0001, 16'hc001);
      $display("test conversion done");
      give_verdict();
   end
endmodule : php_port_tb_top
